// >>> rtl/tw_target.sv
// Two-wire bus target giving access to the 8-bit and 16-bit register file
`timescale 1ns/1ps
module tw_target (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      scl_clk,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe,
    input  wire tw_target_pkg::strap_t     addr_strap,
    output tw_target_pkg::reg_write_t      reg_wr
);
    import tw_target_pkg::*;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_ptr,
        st_wdat,
        st_rdat,
        st_ignore
    } state_t;
    state_t      state_r;
    logic        link_bit_r;
    logic        scl_meta_r;
    logic        scl_sync_r;
    logic        scl_prev_r;
    logic        sda_meta_r;
    logic        sda_sync_r;
    logic        sda_prev_r;
    strap_t      strap_meta_r;
    strap_t      strap_sync_r;
    logic [6:0]  dev_addr_r;
    logic [3:0]  cnt_r;
    logic [7:0]  shreg_r;
    logic        ack_in_r;
    logic [7:0]  ptr_r;
    logic [7:0]  hi_r;
    logic        wr_lo_r;
    logic        rd_lo_r;
    logic [7:0]  tx_r;
    logic        sda_oe_r;
    logic        sda_o_r;
    reg_write_t  reg_wr_r;
    logic [15:0] regs_r [0:REG_COUNT-1];
    logic        rise_evt;
    logic        fall_evt;
    logic        start_evt;
    logic        stop_evt;
    logic        byte_done;
    logic        slot_end;
    logic        addr_hit;
    logic        ack_now;
    logic        load_tx;
    logic        wide;
    logic        wr_fire;
    logic        ptr_load;
    logic [15:0] cur_word;
    logic [7:0]  tx_byte;
    logic [15:0] wr_data;
    function automatic logic is_wide(input logic [7:0] p);
        return (p >= REG_RES_FIRST && p <= REG_RES_LAST) ||
               p == REG_CONFIG ||
               (p >= REG_LIM_FIRST && p <= REG_LIM_LAST);
    endfunction
    function automatic logic [6:0] weight(input logic [1:0] code);
        return (code == STRAP_HIGH)  ? WEIGHT_HIGH :
               (code == STRAP_FLOAT) ? WEIGHT_NC : WEIGHT_LOW;
    endfunction

    // Bit taken on the bus clock's rise; the core reads it only after its
    // synchronised copy of that rise, by which time the flop has settled
    always_ff @(posedge scl_clk) begin
        link_bit_r <= sda_i;
    end

    // Pin synchronisers; the bus idles high
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= scl_clk;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
            sda_meta_r <= sda_i;
            sda_sync_r <= sda_meta_r;
            sda_prev_r <= sda_sync_r;
        end
    end

    // Straps may move while the board settles, so the address follows them
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_meta_r <= '0;
            strap_sync_r <= '0;
            dev_addr_r   <= ADDR_BASE;
        end else begin
            strap_meta_r <= addr_strap;
            strap_sync_r <= strap_meta_r;
            dev_addr_r   <= ADDR_BASE
                          + weight(strap_sync_r.high) * ADDR_W_HIGH
                          + weight(strap_sync_r.mid) * ADDR_W_MID
                          + weight(strap_sync_r.low);
        end
    end

    assign rise_evt  = scl_sync_r & ~scl_prev_r;
    assign fall_evt  = ~scl_sync_r & scl_prev_r;
    // Both lines pass equal synchroniser depth, so their order is kept
    assign start_evt = scl_sync_r & scl_prev_r
                     & sda_prev_r & ~sda_sync_r;
    assign stop_evt  = scl_sync_r & scl_prev_r
                     & ~sda_prev_r & sda_sync_r;
    assign byte_done = fall_evt && cnt_r == BIT_ACK;
    assign slot_end  = fall_evt && cnt_r == BIT_DONE;
    assign addr_hit  = shreg_r[7:1] == dev_addr_r;
    assign wide      = is_wide(ptr_r);
    assign ack_now   = byte_done &&
                       ((state_r == st_addr && addr_hit) ||
                        state_r == st_ptr || state_r == st_wdat);
    assign load_tx   = slot_end && state_r == st_rdat && !ack_in_r;
    assign wr_fire   = byte_done && state_r == st_wdat
                     && !(wide && !wr_lo_r);
    assign ptr_load  = byte_done && state_r == st_ptr;
    assign cur_word  = (ptr_r < REG_LIMIT) ? regs_r[ptr_r[IDX_W-1:0]]
                                           : REG_RESET;
    assign tx_byte   = (wide && !rd_lo_r) ? cur_word[15:8]
                                          : cur_word[7:0];
    assign wr_data   = wide ? {hi_r, shreg_r} : 16'(shreg_r);

    // Bit slot counter and receive shifter
    always_ff @(posedge clk) begin
        if (!nrst || start_evt || stop_evt) begin
            cnt_r <= '0;
        end else if (rise_evt && cnt_r != BIT_DONE) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (slot_end) begin
            cnt_r <= '0;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            shreg_r  <= '0;
            ack_in_r <= 1'b1;
        end else if (rise_evt && cnt_r < BIT_ACK) begin
            shreg_r  <= {shreg_r[6:0], link_bit_r};
        end else if (rise_evt && cnt_r == BIT_ACK) begin
            // Also samples our own acknowledge, which opens a read
            ack_in_r <= link_bit_r;
        end
    end

    // Transaction sequencer, pointer and byte pairing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= st_idle;
            ptr_r   <= PTR_RESET;
            hi_r    <= '0;
            wr_lo_r <= 1'b0;
            rd_lo_r <= 1'b0;
        end else if (start_evt) begin
            state_r <= st_addr;
        end else if (stop_evt) begin
            state_r <= st_idle;
        end else if (byte_done) begin
            case (state_r)
                st_addr: begin
                    if (!addr_hit) begin
                        state_r <= st_ignore;
                    end else if (shreg_r[0] == DIR_READ) begin
                        state_r <= st_rdat;
                        rd_lo_r <= 1'b0;
                    end else begin
                        state_r <= st_ptr;
                    end
                end
                st_ptr: begin
                    ptr_r   <= shreg_r;
                    wr_lo_r <= 1'b0;
                    state_r <= st_wdat;
                end
                st_wdat: begin
                    if (wide && !wr_lo_r) begin
                        hi_r    <= shreg_r;
                        wr_lo_r <= 1'b1;
                    end else begin
                        wr_lo_r <= 1'b0;
                        state_r <= st_ptr;
                    end
                end
                default: begin
                end
            endcase
        end else if (load_tx) begin
            rd_lo_r <= wide & ~rd_lo_r;
        end else if (slot_end && state_r == st_rdat) begin
            state_r <= st_ignore;
        end
    end

    // Open-drain data drive: acknowledge slots and read data bits
    always_ff @(posedge clk) begin
        if (!nrst || start_evt || stop_evt) begin
            sda_oe_r <= 1'b0;
            tx_r     <= '0;
        end else if (byte_done) begin
            sda_oe_r <= ack_now;
        end else if (slot_end) begin
            sda_oe_r <= load_tx && !tx_byte[7];
            tx_r     <= tx_byte;
        end else if (fall_evt && state_r == st_rdat
                     && cnt_r != '0 && cnt_r < BIT_ACK) begin
            sda_oe_r <= !tx_r[6];
            tx_r     <= {tx_r[6:0], 1'b0};
        end
    end

    // Line is only ever pulled low
    always_ff @(posedge clk) begin
        sda_o_r <= 1'b0;
    end

    // Register file; narrow registers keep their byte in the low half
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= REG_RESET;
            end
        end else if (wr_fire && ptr_r < REG_LIMIT) begin
            regs_r[ptr_r[IDX_W-1:0]] <= wr_data;
        end
    end

    // Write notice to the rest of the device, one cycle long
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_wr_r <= '0;
        end else begin
            reg_wr_r.valid <= wr_fire;
            reg_wr_r.addr  <= ptr_r;
            reg_wr_r.data  <= wr_data;
        end
    end
    assign sda_o  = sda_o_r;
    assign sda_oe = sda_oe_r;
    assign reg_wr = reg_wr_r;
    property p_addr_range;
        @(posedge clk) disable iff (!nrst)
        dev_addr_r >= ADDR_BASE && dev_addr_r <= ADDR_TOP;
    endproperty
    a_addr_range: assert property (p_addr_range)
        else $error("bus address outside strap range");
    // The bus clock spends at least ten core cycles per bit slot
    property p_ack_addr;
        @(posedge clk) disable iff (!nrst)
        byte_done && state_r == st_addr && addr_hit
        |=> sda_oe_r [*8];
    endproperty
    a_ack_addr: assert property (p_ack_addr)
        else $error("matching address not acknowledged");
    property p_nomatch;
        @(posedge clk) disable iff (!nrst)
        byte_done && state_r == st_addr && !addr_hit
        |=> state_r == st_ignore && !sda_oe_r;
    endproperty
    a_nomatch: assert property (p_nomatch)
        else $error("foreign address drove the bus");
    property p_ack_data;
        @(posedge clk) disable iff (!nrst)
        byte_done && (state_r == st_ptr || state_r == st_wdat)
        |=> sda_oe_r;
    endproperty
    a_ack_data: assert property (p_ack_data)
        else $error("written byte not acknowledged");
    property p_wide_pair;
        @(posedge clk) disable iff (!nrst)
        wr_fire && wide
        |=> reg_wr_r.valid && reg_wr_r.data == {$past(hi_r), $past(shreg_r)};
    endproperty
    a_wide_pair: assert property (p_wide_pair)
        else $error("16-bit write not combined high first");
    property p_narrow;
        @(posedge clk) disable iff (!nrst)
        wr_fire && !wide |=> reg_wr_r.valid && reg_wr_r.data[15:8] == '0;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("8-bit write carried a high byte");
    property p_chain;
        @(posedge clk) disable iff (!nrst)
        wr_fire && !start_evt && !stop_evt |=> state_r == st_ptr;
    endproperty
    a_chain: assert property (p_chain)
        else $error("next byte not taken as pointer");
    property p_ptr_keep;
        @(posedge clk) disable iff (!nrst)
        ptr_r != $past(ptr_r) |-> $past(ptr_load);
    endproperty
    a_ptr_keep: assert property (p_ptr_keep)
        else $error("pointer moved without a pointer write");
    property p_release;
        @(posedge clk) disable iff (!nrst)
        slot_end && state_r == st_rdat && ack_in_r
        |=> !sda_oe_r && state_r == st_ignore;
    endproperty
    a_release: assert property (p_release)
        else $error("data still driven after missing acknowledge");
    property p_read_dir;
        @(posedge clk) disable iff (!nrst)
        byte_done && state_r == st_addr && addr_hit && shreg_r[0]
        |=> state_r == st_rdat ##1 !$rose(ptr_load);
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("read address did not open a read");

endmodule

// >>> rtl/tw_target_pkg.sv
// Constants and carrier types for the two-wire register target
package tw_target_pkg;

    // Bus address formed from three three-state straps
    localparam logic [6:0] ADDR_BASE   = 7'h61;
    localparam logic [6:0] ADDR_TOP    = 7'h7B;
    localparam logic [6:0] ADDR_W_HIGH = 7'h09;
    localparam logic [6:0] ADDR_W_MID  = 7'h03;
    localparam logic [6:0] WEIGHT_LOW  = 7'h00;
    localparam logic [6:0] WEIGHT_HIGH = 7'h01;
    localparam logic [6:0] WEIGHT_NC   = 7'h02;
    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_HIGH  = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    localparam logic       DIR_READ    = 1'b1;

    // Register map
    localparam int         REG_COUNT     = 40;
    localparam int         IDX_W         = 6;
    localparam logic [7:0] REG_LIMIT     = 8'h28;
    localparam logic [7:0] REG_CMD       = 8'h00;
    localparam logic [7:0] REG_RES_FIRST = 8'h01;
    localparam logic [7:0] REG_RES_LAST  = 8'h04;
    localparam logic [7:0] REG_ALERT_A   = 8'h05;
    localparam logic [7:0] REG_ALERT_C   = 8'h07;
    localparam logic [7:0] REG_CHSEQ     = 8'h08;
    localparam logic [7:0] REG_CONFIG    = 8'h09;
    localparam logic [7:0] REG_PWRDN     = 8'h0A;
    localparam logic [7:0] REG_LIM_FIRST = 8'h0B;
    localparam logic [7:0] REG_LIM_LAST  = 8'h25;
    localparam logic [7:0] REG_TOFS_ONE  = 8'h26;
    localparam logic [7:0] REG_TOFS_TWO  = 8'h27;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [7:0] PTR_RESET     = 8'h00;

    // Bit slot counter: eight data bits, then the acknowledge slot
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    typedef struct packed {
        logic [1:0] high;
        logic [1:0] mid;
        logic [1:0] low;
    } strap_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } reg_write_t;

endpackage

// >>> verif/tb.sv
// Self-checking bench for the two-wire register target
`timescale 1ns/1ps
module tb;
    import tw_target_pkg::*;
    logic        clk;
    logic        nrst;
    logic        sda_o;
    logic        sda_oe;
    logic        scl;
    logic        pull;
    logic        sda;
    strap_t      strap;
    reg_write_t  reg_wr;
    int          miscompares;
    int          total_checks;
    logic [23:0] wq[$];
    logic [7:0]  q;
    logic        ack;
    logic [6:0]  a;
    strap_t      straps[4] = '{'{2'h0, 2'h0, 2'h0}, '{2'h2, 2'h2, 2'h2},
                               '{2'h1, 2'h2, 2'h0}, '{2'h3, 2'h1, 2'h2}};

    // Open-drain wire with pull-up
    assign sda = ~((sda_oe & ~sda_o) | pull);

    tw_target uut (
        .clk        (clk),
        .nrst       (nrst),
        .scl_clk    (scl),
        .sda_i      (sda),
        .sda_o      (sda_o),
        .sda_oe     (sda_oe),
        .addr_strap (strap),
        .reg_wr     (reg_wr)
    );

    tw_ctrl_model ctl (
        .scl  (scl),
        .pull (pull),
        .sda  (sda)
    );

    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (reg_wr.valid === 1'b1) begin
            wq.push_back({reg_wr.addr, reg_wr.data});
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input logic [23:0] exp);
        logic [23:0] g;
        g = (wq.size() > 0) ? wq.pop_front() : 24'hxx_xxxx;
        total_checks++;
        if (g !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, exp);
        end
    endtask

    // Byte towards the target; the target must acknowledge
    task automatic wb(input logic [7:0] d);
        ctl.xfer(d, 1'b1, q, ack);
        chk_byte({7'h00, ack}, 8'h00);
    endtask

    // Byte from the target; last one is not acknowledged
    task automatic rb(input logic [7:0] exp, input logic last);
        ctl.xfer(8'hFF, last, q, ack);
        chk_byte(q, exp);
    endtask

    function automatic int wt(logic [1:0] c);
        return (c == STRAP_HIGH) ? 1 : (c == STRAP_FLOAT) ? 2 : 0;
    endfunction

    function automatic logic [6:0] addr_of(strap_t s);
        return ADDR_BASE + 7'(9 * wt(s.high) + 3 * wt(s.mid) + wt(s.low));
    endfunction

    // Cuts a hang short
    initial begin
        #400_000;
        miscompares++;
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        strap = straps[0];
        miscompares = 0;
        total_checks = 0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        #3;
        foreach (straps[i]) begin
            @(negedge clk) strap = straps[i];
            #83;
            a = addr_of(straps[i]);
            ctl.start();
            ctl.xfer({a ^ 7'h01, 1'b0}, 1'b1, q, ack);
            chk_byte({7'h00, ack}, 8'h01);
            ctl.xfer(8'h05, 1'b1, q, ack);
            chk_byte({7'h00, ack}, 8'h01);
            ctl.stop();
            ctl.start();
            wb({a, 1'b0});
            ctl.stop();
        end
        // Mixed widths in one write, then a lone high byte
        ctl.start();
        wb({a, 1'b0});
        wb(REG_ALERT_A);
        wb(8'hA5);
        wb(REG_CONFIG);
        wb(8'h12);
        wb(8'h34);
        wb(REG_TOFS_TWO);
        wb(8'h5C);
        ctl.stop();
        ctl.start();
        wb({a, 1'b0});
        wb(8'h0B);
        wb(8'hEE);
        ctl.stop();
        chk_wr(24'h05_00A5);
        chk_wr(24'h09_1234);
        chk_wr(24'h27_005C);
        chk_byte(8'(wq.size()), 8'h00);
        // Pointer write chained to a read by repeated start
        ctl.start();
        wb({a, 1'b0});
        wb(REG_CONFIG);
        ctl.start();
        wb({a, DIR_READ});
        rb(8'h12, 1'b0);
        rb(8'h34, 1'b0);
        rb(8'h12, 1'b0);
        rb(8'h34, 1'b1);
        #40;
        chk_byte({7'h00, sda_oe}, 8'h00);
        chk_byte({7'h00, sda_o}, 8'h00);
        ctl.stop();
        ctl.start();
        wb({a, DIR_READ});
        rb(8'h12, 1'b1);
        ctl.stop();
        // Byte-wide register reads repeat the same byte
        ctl.start();
        wb({a, 1'b0});
        wb(REG_ALERT_A);
        ctl.stop();
        ctl.start();
        wb({a, DIR_READ});
        rb(8'hA5, 1'b0);
        rb(8'hA5, 1'b1);
        ctl.stop();
        // Unmapped pointer: acknowledged, reads back zero
        ctl.start();
        wb({a, 1'b0});
        wb(8'h30);
        wb(8'h77);
        ctl.stop();
        ctl.start();
        wb({a, DIR_READ});
        rb(8'h00, 1'b1);
        ctl.stop();
        wrap_up();
    end
endmodule

// >>> verif/tw_ctrl_model.sv
// Two-wire bus controller model that drives the target's link pins
`timescale 1ns/1ps
module tw_ctrl_model (
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    // Clock stands high between frames; released data floats up
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end

    // One bit slot, entered 24 ns into the low phase
    task automatic slot(input logic b, output logic r);
        pull = ~b;
        #16 scl = 1'b1;
        #24 r = sda;
        #16 scl = 1'b0;
        #24;
    endtask

    // Start and repeated start: data falls while clock is high
    task automatic start();
        pull = 1'b0;
        #16 scl = 1'b1;
        #40 pull = 1'b1;
        #40 scl = 1'b0;
        #24;
    endtask

    // Stop: data rises while clock is high, leaving the bus idle
    task automatic stop();
        pull = 1'b1;
        #16 scl = 1'b1;
        #40 pull = 1'b0;
        #40;
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], q[i]);
        end
        slot(ack_in, ack_out);
    endtask
endmodule
